// ==== ascoh_pkg.sv ====
// Constants, register map and state codes for the attribute space host controller
//
// Functional notes
// - Attribute accesses byte wide, even addresses, low lane; the word command bit still asserts the odd byte enable
// - Read holds select and read strobe, write idle
// - Drop enables or both strobes between cycles
// - Storage-class host writes index bits 5,4 zero; masked on option commands only, direct address writes to 0x200 pass unmasked
package ascoh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int          T_SETUP_NS      = 30;
  localparam int          T_STROBE_NS     = 300;
  localparam int          T_HOLD_NS       = 20;
  localparam int          T_RECOVER_NS    = 100;

  function automatic int ascoh_min_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int          SETUP_CYC       = ascoh_min_cyc(T_SETUP_NS);
  localparam int          STROBE_CYC      = ascoh_min_cyc(T_STROBE_NS);
  localparam int          HOLD_CYC        = ascoh_min_cyc(T_HOLD_NS);
  localparam int          RECOVER_CYC     = ascoh_min_cyc(T_RECOVER_NS);
  localparam int          SYNC_STAGES     = 2;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          CARD_AW         = 11;
  localparam int          CARD_DW         = 16;
  localparam int          TMR_W           = 8;
  localparam logic [10:0] STORAGE_CFG_BASE = 11'h200;
  localparam logic [10:0] OPT_OFFSET      = 11'h000;
  localparam logic [1:0]  STORAGE_CFG_SEL = 2'h1;
  localparam logic [10:0] EXP_CFG_WINDOW  = 11'h03f;

  // Option register fields in the card
  localparam int          OPT_SOFTRST_BIT = 7;
  localparam int          OPT_LEVEL_BIT   = 6;
  localparam logic [7:0]  OPT_STORAGE_MASK = 8'hcf;
  localparam logic [7:0]  OPT_RESET_VAL   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Own register map on the Wishbone side
  localparam logic [7:0]  OFF_CMD         = 8'h00;
  localparam logic [7:0]  OFF_ADDR        = 8'h04;
  localparam logic [7:0]  OFF_WDATA       = 8'h08;
  localparam logic [7:0]  OFF_STATUS      = 8'h0c;
  localparam logic [7:0]  OFF_SETUP       = 8'h10;
  localparam logic [7:0]  OFF_CFG_BASE    = 8'h14;

  localparam int          CMD_GO_BIT      = 0;
  localparam int          CMD_WRITE_BIT   = 1;
  localparam int          CMD_WORD_BIT    = 2;
  localparam int          CMD_OPT_BIT     = 3;

  localparam int          ST_BUSY_BIT     = 8;
  localparam int          ST_DONE_BIT     = 9;
  localparam int          ST_REFUSED_BIT  = 10;
  localparam int          ST_IRQ_BIT      = 11;
  localparam int          ST_OPT_LSB      = 16;

  localparam int          SET_STORAGE_BIT = 0;
  localparam int          SET_HWRST_BIT   = 1;
  localparam logic        STORAGE_RST     = 1'b1;
  localparam logic        HWRST_RST       = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SETUP   = 5'b00010,
    ST_STROBE  = 5'b00100,
    ST_HOLD    = 5'b01000,
    ST_RECOVER = 5'b10000
  } ascoh_state_type;

endpackage

// ==== ascoh_sync.sv ====
// Two-stage synchroniser for card pin inputs
`timescale 1ns/1ps
module ascoh_sync
  import ascoh_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_comb
      begin
        meta_nxt[g] = i_async[g];
        sync_nxt[g] = meta_r[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      // Idle level of each pin, so no false event follows reset
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule // ascoh_sync

// ==== ascoh_timer.sv ====
// Phase length counter for the card cycle engine
`timescale 1ns/1ps
module ascoh_timer
  import ascoh_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_len,
  output logic              o_last
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb
  begin
    if (i_start)
      cnt_nxt = i_len;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
    else
      cnt_nxt = cnt_r;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // Last cycle of a phase; a phase lasts i_len cycles, and an i_len of zero never ends it
  assign o_last = (cnt_r == {{(W-1){1'b0}}, 1'b1});

endmodule // ascoh_timer

// ==== ascoh_host.sv ====
// Host controller for card attribute space and configuration option register
`timescale 1ns/1ps
module ascoh_host
  import ascoh_pkg::*;
#(
  parameter int SETUP_LEN   = SETUP_CYC,
  parameter int STROBE_LEN  = STROBE_CYC,
  parameter int HOLD_LEN    = HOLD_CYC,
  parameter int RECOVER_LEN = RECOVER_CYC
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [7:0]          i_wb_adr,
  input  wire logic [3:0]          i_wb_sel,
  input  wire logic [31:0]         i_wb_dat,
  output logic      [31:0]         o_wb_dat,
  output logic                     o_wb_ack,
  output logic                     o_even_byte_card_enable_n,
  output logic                     o_odd_byte_card_enable_n,
  output logic                     o_attr_select_n,
  output logic                     o_read_strobe_n,
  output logic                     o_write_strobe_n,
  output logic      [CARD_AW-1:0]  o_card_addr,
  output logic      [CARD_DW-1:0]  o_card_data,
  output logic                     o_card_data_oe_n,
  input  wire logic [CARD_DW-1:0]  i_card_data,
  input  wire logic                i_card_interrupt_line_n,
  output logic                     o_card_hw_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: data lanes and interrupt line
  logic [CARD_DW:0] pin_sync;
  logic             irq_active;

  ascoh_sync #(
    .W       (CARD_DW + 1),
    .RST_VAL ({1'b1, {CARD_DW{1'b0}}})
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_card_interrupt_line_n, i_card_data}),
    .o_sync    (pin_sync)
  );

  assign irq_active = ~pin_sync[CARD_DW];

  ////////////////////////////////////////////////////////////////////////////
  // Bus-side registers
  logic               ack_r;
  logic               ack_nxt;
  logic [31:0]        wb_dat_r;
  logic [31:0]        wb_dat_nxt;
  logic [CARD_AW-1:0] addr_r;
  logic [CARD_AW-1:0] addr_nxt;
  logic [7:0]         wdata_r;
  logic [7:0]         wdata_nxt;
  logic               storage_r;
  logic               storage_nxt;
  logic               hwrst_r;
  logic               hwrst_nxt;
  logic [CARD_AW-1:0] cfg_base_r;
  logic [CARD_AW-1:0] cfg_base_nxt;
  logic               done_r;
  logic               done_nxt;
  logic               refused_r;
  logic               refused_nxt;

  // Engine registers
  ascoh_state_type    state_r;
  ascoh_state_type    state_nxt;
  logic               cur_write_r;
  logic               cur_write_nxt;
  logic               cur_word_r;
  logic               cur_word_nxt;
  logic               cur_opt_r;
  logic               cur_opt_nxt;
  logic [CARD_AW-1:0] cyc_addr_r;
  logic [CARD_AW-1:0] cyc_addr_nxt;
  logic [7:0]         cyc_data_r;
  logic [7:0]         cyc_data_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic [7:0]         opt_shadow_r;
  logic [7:0]         opt_shadow_nxt;

  // Shared combinational terms
  logic               wb_req;
  logic               wr_commit;
  logic               cmd_go;
  logic               go_write;
  logic               go_word;
  logic               go_opt;
  logic [CARD_AW-1:0] cfg_base;
  logic [CARD_AW-1:0] target;
  logic [7:0]         go_data;
  logic               write_ok;
  logic               bad_req;
  logic               accept;
  logic               refuse;
  logic               ev_done;
  logic               tmr_start;
  logic [TMR_W-1:0]   tmr_len;
  logic               tmr_last;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode and host-side legality checks
  always_comb
  begin
    wb_req    = i_wb_cyc & i_wb_stb;
    wr_commit = wb_req & ack_r & i_wb_we;
    cmd_go    = wr_commit & i_wb_sel[0] & (i_wb_adr == OFF_CMD) & i_wb_dat[CMD_GO_BIT];
    go_write  = i_wb_dat[CMD_WRITE_BIT];
    go_word   = i_wb_dat[CMD_WORD_BIT];
    go_opt    = i_wb_dat[CMD_OPT_BIT];
    cfg_base  = storage_r ? STORAGE_CFG_BASE : cfg_base_r;
    target    = go_opt ? CARD_AW'(cfg_base + OPT_OFFSET) : addr_r;
    go_data   = wdata_r;
    if (storage_r && go_opt)
      go_data = wdata_r & OPT_STORAGE_MASK;
    if (storage_r)
      write_ok = (target[10:9] == STORAGE_CFG_SEL);
    else
      write_ok = (target >= cfg_base) && ((target - cfg_base) <= EXP_CFG_WINDOW);
    bad_req   = target[0] | (go_write & ~write_ok);
    accept    = cmd_go & (state_r == ST_IDLE) & ~bad_req & ~hwrst_r;
    refuse    = cmd_go & ~accept;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, writes land at the ack edge
  always_comb
  begin
    ack_nxt      = wb_req & ~ack_r;
    wb_dat_nxt   = wb_dat_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    storage_nxt  = storage_r;
    hwrst_nxt    = hwrst_r;
    cfg_base_nxt = cfg_base_r;
    done_nxt     = done_r;
    refused_nxt  = refused_r;
    if (ack_nxt)
    begin
      wb_dat_nxt = 32'h0000_0000;
      case (i_wb_adr)
        OFF_ADDR:     wb_dat_nxt[CARD_AW-1:0] = addr_r;
        OFF_WDATA:    wb_dat_nxt[7:0] = wdata_r;
        OFF_STATUS:
        begin
          wb_dat_nxt[7:0]                   = rdata_r;
          wb_dat_nxt[ST_BUSY_BIT]           = (state_r != ST_IDLE);
          wb_dat_nxt[ST_DONE_BIT]           = done_r;
          wb_dat_nxt[ST_REFUSED_BIT]        = refused_r;
          wb_dat_nxt[ST_IRQ_BIT]            = irq_active;
          wb_dat_nxt[ST_OPT_LSB+7:ST_OPT_LSB] = opt_shadow_r;
        end
        OFF_SETUP:
        begin
          wb_dat_nxt[SET_STORAGE_BIT] = storage_r;
          wb_dat_nxt[SET_HWRST_BIT]   = hwrst_r;
        end
        OFF_CFG_BASE: wb_dat_nxt[CARD_AW-1:0] = cfg_base_r;
        default:      wb_dat_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_commit)
    begin
      case (i_wb_adr)
        OFF_ADDR:
        begin
          if (i_wb_sel[0])
            addr_nxt[7:0] = i_wb_dat[7:0];
          if (i_wb_sel[1])
            addr_nxt[CARD_AW-1:8] = i_wb_dat[CARD_AW-1:8];
        end
        OFF_WDATA:
          if (i_wb_sel[0])
            wdata_nxt = i_wb_dat[7:0];
        OFF_STATUS:
        begin
          if (i_wb_sel[1] && i_wb_dat[ST_DONE_BIT])
            done_nxt = 1'b0;
          if (i_wb_sel[1] && i_wb_dat[ST_REFUSED_BIT])
            refused_nxt = 1'b0;
        end
        OFF_SETUP:
          if (i_wb_sel[0] && (state_r == ST_IDLE))
          begin
            storage_nxt = i_wb_dat[SET_STORAGE_BIT];
            hwrst_nxt   = i_wb_dat[SET_HWRST_BIT];
          end
        OFF_CFG_BASE:
        begin
          if (i_wb_sel[0])
            cfg_base_nxt[7:0] = i_wb_dat[7:0];
          if (i_wb_sel[1])
            cfg_base_nxt[CARD_AW-1:8] = i_wb_dat[CARD_AW-1:8];
        end
        default: ;
      endcase
    end
    // Hardware sets win over a clear in the same cycle
    if (ev_done)
      done_nxt = 1'b1;
    if (refuse)
      refused_nxt = 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ack_r      <= 1'b0;
      wb_dat_r   <= 32'h0000_0000;
      addr_r     <= 11'h000;
      wdata_r    <= 8'h00;
      storage_r  <= STORAGE_RST;
      hwrst_r    <= HWRST_RST;
      cfg_base_r <= STORAGE_CFG_BASE;
      done_r     <= 1'b0;
      refused_r  <= 1'b0;
    end
    else
    begin
      ack_r      <= ack_nxt;
      wb_dat_r   <= wb_dat_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      storage_r  <= storage_nxt;
      hwrst_r    <= hwrst_nxt;
      cfg_base_r <= cfg_base_nxt;
      done_r     <= done_nxt;
      refused_r  <= refused_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card cycle engine: setup, strobe, hold, recovery with enables released
  ascoh_timer #(
    .W (TMR_W)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (tmr_start),
    .i_len     (tmr_len),
    .o_last    (tmr_last)
  );

  assign ev_done = (state_r == ST_RECOVER) & tmr_last;

  always_comb
  begin
    state_nxt      = state_r;
    cur_write_nxt  = cur_write_r;
    cur_word_nxt   = cur_word_r;
    cur_opt_nxt    = cur_opt_r;
    cyc_addr_nxt   = cyc_addr_r;
    cyc_data_nxt   = cyc_data_r;
    rdata_nxt      = rdata_r;
    opt_shadow_nxt = opt_shadow_r;
    tmr_start      = 1'b0;
    tmr_len        = TMR_W'(SETUP_LEN);
    case (state_r)
      ST_IDLE:
        if (accept)
        begin
          state_nxt     = ST_SETUP;
          cur_write_nxt = go_write;
          cur_word_nxt  = go_word;
          cur_opt_nxt   = go_opt;
          cyc_addr_nxt  = target;
          cyc_data_nxt  = go_data;
          tmr_start     = 1'b1;
          tmr_len       = TMR_W'(SETUP_LEN);
        end
      ST_SETUP:
        if (tmr_last)
        begin
          state_nxt = ST_STROBE;
          tmr_start = 1'b1;
          tmr_len   = TMR_W'(STROBE_LEN);
        end
      ST_STROBE:
        if (tmr_last)
        begin
          // Synchronised lanes lag two cycles, so strobe must exceed that
          if (!cur_write_r)
            rdata_nxt = pin_sync[7:0];
          state_nxt = ST_HOLD;
          tmr_start = 1'b1;
          tmr_len   = TMR_W'(HOLD_LEN);
        end
      ST_HOLD:
        if (tmr_last)
        begin
          state_nxt = ST_RECOVER;
          tmr_start = 1'b1;
          tmr_len   = TMR_W'(RECOVER_LEN);
        end
      ST_RECOVER:
        if (tmr_last)
        begin
          state_nxt = ST_IDLE;
          if (cur_opt_r)
            opt_shadow_nxt = cur_write_r ? cyc_data_r : rdata_r;
        end
      default: state_nxt = ST_IDLE;
    endcase
    // Card hardware reset clears every option field the host tracks
    if (hwrst_r)
      opt_shadow_nxt = OPT_RESET_VAL;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_r      <= ST_IDLE;
      cur_write_r  <= 1'b0;
      cur_word_r   <= 1'b0;
      cur_opt_r    <= 1'b0;
      cyc_addr_r   <= 11'h000;
      cyc_data_r   <= 8'h00;
      rdata_r      <= 8'h00;
      opt_shadow_r <= OPT_RESET_VAL;
    end
    else
    begin
      state_r      <= state_nxt;
      cur_write_r  <= cur_write_nxt;
      cur_word_r   <= cur_word_nxt;
      cur_opt_r    <= cur_opt_nxt;
      cyc_addr_r   <= cyc_addr_nxt;
      cyc_data_r   <= cyc_data_nxt;
      rdata_r      <= rdata_nxt;
      opt_shadow_r <= opt_shadow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; one-hot state bits keep these decodes glitch-light
  logic in_cycle;

  assign in_cycle                   = (state_r == ST_SETUP) | (state_r == ST_STROBE) | (state_r == ST_HOLD);
  assign o_even_byte_card_enable_n  = ~in_cycle;
  assign o_odd_byte_card_enable_n   = ~(in_cycle & cur_word_r);
  assign o_attr_select_n            = ~in_cycle;
  assign o_read_strobe_n            = ~((state_r == ST_STROBE) & ~cur_write_r);
  assign o_write_strobe_n           = ~((state_r == ST_STROBE) & cur_write_r);
  assign o_card_addr                = cyc_addr_r;
  assign o_card_data                = {8'h00, cyc_data_r};
  assign o_card_data_oe_n           = ~(in_cycle & cur_write_r);
  assign o_card_hw_reset            = hwrst_r;
  assign o_wb_ack                   = ack_r;
  assign o_wb_dat                   = wb_dat_r;

endmodule // ascoh_host

// ==== ascoh_properties.sv ====
// Concurrent checks on the card pins of the attribute space host controller
`timescale 1ns/1ps
module ascoh_properties
  import ascoh_pkg::*;
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               o_even_byte_card_enable_n,
  input  wire logic               o_odd_byte_card_enable_n,
  input  wire logic               o_attr_select_n,
  input  wire logic               o_read_strobe_n,
  input  wire logic               o_write_strobe_n,
  input  wire logic [CARD_AW-1:0] o_card_addr,
  input  wire logic [CARD_DW-1:0] o_card_data,
  input  wire logic               o_card_data_oe_n,
  input  wire logic               o_card_hw_reset
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Default strobe phase is three cycles
  sequence s_strobe_run;
    !o_read_strobe_n [*3];
  endsequence
  sequence s_strobe_end;
    $rose(o_read_strobe_n & o_write_strobe_n);
  endsequence

  property p_read_qual;
    !o_read_strobe_n |-> !o_attr_select_n && o_write_strobe_n && !o_even_byte_card_enable_n;
  endproperty
  a_read_qual: assert property (p_read_qual) else $error("read strobe without select");
  property p_read_len;
    $fell(o_read_strobe_n) |-> s_strobe_run;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe too short");
  property p_addr_stable;
    !o_attr_select_n && !$fell(o_attr_select_n) |-> $stable(o_card_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");
  property p_gap;
    s_strobe_end |-> ##[1:4] o_even_byte_card_enable_n;
  endproperty
  a_gap: assert property (p_gap) else $error("enables not dropped between cycles");
  property p_even;
    !o_attr_select_n |-> !o_card_addr[0];
  endproperty
  a_even: assert property (p_even) else $error("odd attribute address");
  property p_no_odd_only;
    !o_odd_byte_card_enable_n |-> !o_even_byte_card_enable_n && !o_attr_select_n;
  endproperty
  a_no_odd_only: assert property (p_no_odd_only) else $error("odd enable only");
  property p_wr_lane;
    !o_write_strobe_n |-> !o_card_data_oe_n && o_card_data[15:8] == 8'h00;
  endproperty
  a_wr_lane: assert property (p_wr_lane) else $error("write data lanes wrong");
  property p_wr_info;
    !o_write_strobe_n |-> o_card_addr[10:9] != 2'b00;
  endproperty
  a_wr_info: assert property (p_wr_info) else $error("write into info structure");
  property p_hw_idle;
    o_card_hw_reset |-> o_attr_select_n && o_even_byte_card_enable_n;
  endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("cycle during card reset");
endmodule // ascoh_properties

bind ascoh_host ascoh_properties u_ascoh_properties (.i_clk_sys, .i_rst, .o_even_byte_card_enable_n,
  .o_odd_byte_card_enable_n, .o_attr_select_n, .o_read_strobe_n, .o_write_strobe_n, .o_card_addr, .o_card_data,
  .o_card_data_oe_n, .o_card_hw_reset);

// ==== ascoh_card_model.sv ====
// Behavioural card: attribute space decode and configuration option register
`timescale 1ns/1ps
module ascoh_card_model
  import ascoh_pkg::*;
(
  input  wire logic               i_ce_even_n,
  input  wire logic               i_ce_odd_n,
  input  wire logic               i_attr_n,
  input  wire logic               i_rd_n,
  input  wire logic               i_wr_n,
  input  wire logic [CARD_AW-1:0] i_addr,
  input  wire logic [CARD_DW-1:0] i_data,
  input  wire logic               i_hw_reset,
  input  wire logic               i_storage,
  input  wire logic [10:0]        i_base,
  input  wire logic               i_irq_req,
  output logic      [CARD_DW-1:0] o_data,
  output logic                    o_irq_n
);
  logic [7:0]  opt_r = 8'h00;
  logic [7:0]  last_r = 8'h00;
  logic [7:0]  rd_byte;
  logic [10:0] base;
  logic        valid;
  logic        sel_cfg;
  logic [1:0]  map_mode;
  logic        io_filter;

  ////////////////////////////////////////////////////////////////////////////
  assign base    = i_storage ? STORAGE_CFG_BASE : i_base;
  assign valid   = !i_attr_n && !i_ce_even_n && !i_addr[0];
  assign sel_cfg = valid && i_addr == base + OPT_OFFSET && (!i_storage || i_addr[10:9] == 2'b01);
  // Info structure is a fixed pattern, so stray writes cannot alter it
  assign rd_byte = sel_cfg ? opt_r : i_addr[7:0] ^ 8'h5a;
  assign o_data[7:0]  = (valid && !i_rd_n) ? rd_byte : ~last_r;
  assign o_data[15:8] = (valid && !i_rd_n && !i_ce_odd_n) ? ~rd_byte : 8'hzz;
  assign o_irq_n = !(i_irq_req && opt_r[0] && opt_r[2]);
  // Storage mapping from index 0 to 3; higher indices fall back to memory
  assign map_mode  = (i_storage && opt_r[5:2] == 4'h0) ? opt_r[1:0] : 2'h0;
  // Function I/O passes base and limit filter only while enabled
  assign io_filter = opt_r[0] && opt_r[1];

  always @(posedge i_rd_n)
    last_r <= rd_byte;

  // Soft reset bit is kept as written
  always @(posedge i_wr_n or posedge i_hw_reset)
    if (i_hw_reset)
      opt_r <= 8'h00;
    else if (sel_cfg)
      opt_r <= i_data[7:0];
endmodule // ascoh_card_model

// ==== test_attribute_space_config_option.sv ====
// Self-checking bench for the attribute space host controller
`timescale 1ns/1ps
module test_attribute_space_config_option
  import ascoh_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        wdat = 32'h0;
  logic [31:0]        rdat;
  logic [31:0]        st;
  logic [31:0]        q;
  logic               ack, ce_e_n, ce_o_n, attr_n, rd_n, wr_n, oe_n, irq_n, hw_rst;
  logic               storage = 1'b1;
  logic               irq_req = 1'b0;
  logic [10:0]        caddr;
  logic [15:0]        hdata, cdata, wire_data;
  int                 mismatches = 0;
  int                 checked = 0;

  initial forever #50 clk = ~clk;
  // Host drives lanes only while its enable is low
  assign wire_data = oe_n ? cdata : hdata;

  ascoh_host u_ascoh_host (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_even_byte_card_enable_n(ce_e_n), .o_odd_byte_card_enable_n(ce_o_n), .o_attr_select_n(attr_n),
    .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_card_addr(caddr), .o_card_data(hdata),
    .o_card_data_oe_n(oe_n), .i_card_data(wire_data), .i_card_interrupt_line_n(irq_n),
    .o_card_hw_reset(hw_rst));
  ascoh_card_model u_ascoh_card_model (.i_ce_even_n(ce_e_n), .i_ce_odd_n(ce_o_n), .i_attr_n(attr_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(caddr), .i_data(wire_data), .i_hw_reset(hw_rst),
    .i_storage(storage), .i_base(11'h480), .i_irq_req(irq_req), .o_data(cdata), .o_irq_n(irq_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      stop_test();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Issues a card command, polls to completion, then clears the sticky flags
  task automatic card(input logic [31:0] cmd, output logic [31:0] s);
    int n;
    wb(1'b1, OFF_CMD, cmd, q);
    n = 0;
    do
    begin
      wb(1'b0, OFF_STATUS, 32'h0, s);
      n++;
    end
    while ((s[ST_BUSY_BIT] !== 1'b0 || (s[ST_DONE_BIT] | s[ST_REFUSED_BIT]) !== 1'b1) && n < 40);
    if (n >= 40)
    begin
      mismatches++;
      stop_test();
    end
    wb(1'b1, OFF_STATUS, 32'h600, q);
  endtask

  task automatic opt_write(input logic [7:0] v);
    wb(1'b1, OFF_WDATA, {24'h0, v}, q);
    card(32'hb, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wb(1'b0, OFF_SETUP, 32'h0, q);
    check("setup", q, 32'h1);
    wb(1'b0, OFF_CFG_BASE, 32'h0, q);
    check("cfg_base", q, 32'h200);
    wb(1'b0, OFF_STATUS, 32'h0, q);
    check("status", q, 32'h0);
    wb(1'b0, 8'h20, 32'h0, q);
    check("unmapped", q, 32'h0);
  endtask

  task automatic t_opt_rw();
    opt_write(8'hf3);
    check("opt_w_ref", st[ST_REFUSED_BIT], 1'b0);
    check("card_opt", u_ascoh_card_model.opt_r, 8'hc3);
    check("map_mode", u_ascoh_card_model.map_mode, 2'h3);
    check("io_filter", u_ascoh_card_model.io_filter, 1'b1);
    card(32'h9, st);
    check("opt_byte_rd", st[7:0], 8'hc3);
    check("opt_shadow", st[23:16], 8'hc3);
    card(32'hd, st);
    check("opt_word_rd", st[7:0], 8'hc3);
  endtask

  task automatic t_refuse();
    wb(1'b1, OFF_ADDR, 32'h201, q);
    card(32'h1, st);
    check("odd_rd_ref", st[ST_REFUSED_BIT], 1'b1);
    wb(1'b1, OFF_ADDR, 32'h0, q);
    card(32'h3, st);
    check("info_wr_ref", st[ST_REFUSED_BIT], 1'b1);
    wb(1'b1, OFF_ADDR, 32'h402, q);
    card(32'h3, st);
    check("a10_wr_ref", st[ST_REFUSED_BIT], 1'b1);
    wb(1'b1, OFF_ADDR, 32'h4, q);
    card(32'h1, st);
    check("info_rd", st[7:0], 8'h5e);
    check("opt_kept", u_ascoh_card_model.opt_r, 8'hc3);
  endtask

  task automatic t_irq();
    logic [7:0] cv[3] = '{8'h05, 8'h01, 8'h04};
    logic       ex[3] = '{1'b1, 1'b0, 1'b0};
    irq_req <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      opt_write(cv[i]);
      wb(1'b0, OFF_STATUS, 32'h0, q);
      check("irq_route", q[ST_IRQ_BIT], ex[i]);
    end
    irq_req <= 1'b0;
  endtask

  task automatic t_hwreset();
    opt_write(8'hc1);
    check("soft_rst_kept", u_ascoh_card_model.opt_r, 8'hc1);
    wb(1'b1, OFF_SETUP, 32'h3, q);
    card(32'h9, st);
    check("hw_ref", st[ST_REFUSED_BIT], 1'b1);
    check("hw_shadow", st[23:16], 8'h00);
    wb(1'b1, OFF_SETUP, 32'h1, q);
    card(32'h9, st);
    check("opt_cleared", st[7:0], 8'h00);
  endtask

  task automatic t_expansion();
    storage <= 1'b0;
    wb(1'b1, OFF_SETUP, 32'h0, q);
    wb(1'b1, OFF_CFG_BASE, 32'h480, q);
    opt_write(8'h3a);
    check("exp_opt", u_ascoh_card_model.opt_r, 8'h3a);
    wb(1'b1, OFF_ADDR, 32'h500, q);
    card(32'h3, st);
    check("exp_out_ref", st[ST_REFUSED_BIT], 1'b1);
    wb(1'b1, OFF_ADDR, 32'h480, q);
    card(32'h1, st);
    check("exp_rd", st[7:0], 8'h3a);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_opt_rw();
    t_refuse();
    t_irq();
    t_hwreset();
    t_expansion();
    stop_test();
  end
endmodule // test_attribute_space_config_option
